// file: rtl/fsp_controller.sv
// Purpose: cpu-side end: APB registers turned into timed control sequences
// Assumes: APB slave, one wait state for register access
// Notes: a command write is refused while a command is still pending
`timescale 1ns/10ps
module fsp_controller import fsp_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EEPROM_WRITE_ACTIVE,
  fsp_if.ctl LINK
);
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_POLL = 4'b0010,
    C_EEW = 4'b0100,
    C_ISSUE = 4'b1000
  } fsp_cstate_type;

  typedef struct packed {
    fsp_cstate_type st;
    logic [7:0] cmd;
    logic [15:0] ptr;
    logic [15:0] data;
    logic pend;
    logic done;
    logic cr_wr;
    logic spm;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fsp_cregs_type;

  fsp_cregs_type r_q, r_d;
  logic acc;

  assign acc = PSEL && PENABLE && !r_q.pready;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_d = r_q;
    r_d.pready = acc;
    r_d.pslverr = 1'b0;
    r_d.prdata = 32'h00000000;
    r_d.cr_wr = 1'b0;
    r_d.spm = 1'b0;
    if (acc) begin
      unique case (PADDR)
        REG_CMD: begin
          if (PWRITE && !r_q.pend) begin
            r_d.cmd = PWDATA[7:0] | 8'h01;
            r_d.pend = 1'b1;
            r_d.done = 1'b0;
          end else if (PWRITE) begin
            r_d.pslverr = 1'b1;
          end
          r_d.prdata = {24'h000000, r_q.cmd};
        end
        REG_PTR: begin
          // pointer bit zero is forced clear for every command
          if (PWRITE) r_d.ptr = {PWDATA[15:1], 1'b0}; // [RQ9]
          r_d.prdata = {16'h0000, r_q.ptr};
        end
        REG_DATA: begin
          if (PWRITE) r_d.data = PWDATA[15:0]; // [RQ15]
          r_d.prdata = {16'h0000, r_q.data};
        end
        REG_STAT: r_d.prdata = {29'h0, r_q.done, LINK.cr_rdata[CR_BUSY], r_q.pend};
        default: r_d.pslverr = 1'b1;
      endcase
    end
    unique case (r_q.st)
      C_IDLE: if (r_q.pend) r_d.st = C_POLL;
      C_POLL: if (!LINK.cr_rdata[CR_ENABLE]) r_d.st = C_EEW; // [RQ13]
      C_EEW: begin
        // interrupts stay off: this end never yields between the two strobes
        if (!EEPROM_WRITE_ACTIVE) begin // [RQ14] [RQ16]
          r_d.cr_wr = 1'b1;
          r_d.st = C_ISSUE;
        end
      end
      C_ISSUE: begin
        r_d.spm = 1'b1; // [RQ17]
        r_d.pend = 1'b0;
        r_d.done = 1'b1;
        r_d.st = C_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      r_q <= '{st: C_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign PRDATA = r_q.prdata;
  assign PREADY = r_q.pready;
  assign PSLVERR = r_q.pslverr;
  assign LINK.cr_wr = r_q.cr_wr;
  assign LINK.cr_wdata = r_q.cmd;
  assign LINK.spm_exec = r_q.spm;
  assign LINK.zptr = r_q.ptr; // [RQ8]
  assign LINK.wdata = r_q.data;
  assign LINK.lock_data = r_q.data[7:0];
  assign LINK.eeprom_write_active = EEPROM_WRITE_ACTIVE;
endmodule

// file: rtl/fsp_if.sv
// Purpose: link between the cpu-side controller and the sequencer
// Assumes: one clock
// Notes: cr_wr loads the control register, spm_exec is the store instruction
`timescale 1ns/10ps
interface fsp_if;
  logic cr_wr;
  logic [7:0] cr_wdata;
  logic [7:0] cr_rdata;
  logic spm_exec;
  logic [15:0] zptr;
  logic [15:0] wdata;
  logic [7:0] lock_data;
  logic eeprom_write_active;
  modport dev (input cr_wr, cr_wdata, spm_exec, zptr, wdata, lock_data, eeprom_write_active,
    output cr_rdata);
  modport ctl (output cr_wr, cr_wdata, spm_exec, zptr, wdata, lock_data, eeprom_write_active,
    input cr_rdata);
endinterface

// file: rtl/fsp_pkg.sv
// Purpose: shared constants for the flash self-program sequencer
// Assumes: 200 MHz core clock, 64 kB flash variant
// Notes: both ends, the bench and the monitor import this package
package fsp_pkg;
  localparam int CLK_MHZ = 200;
  // programming times in microseconds
  localparam int ERASE_MIN_US = 7300;
  localparam int ERASE_MAX_US = 8900;
  localparam int WRITE_MIN_US = 3700;
  localparam int WRITE_MAX_US = 4500;
  // aim at the midpoint; the halving rounds down before scaling to cycles
  localparam int ERASE_CYC = ((ERASE_MIN_US + ERASE_MAX_US) / 2) * CLK_MHZ;
  localparam int WRITE_CYC = ((WRITE_MIN_US + WRITE_MAX_US) / 2) * CLK_MHZ;
  localparam int SPM_WINDOW_CYC = 4;
  localparam int COUNTER_TOP_BIT = 14;
  localparam int PAGE_TOP_BIT = 6;
  localparam int PAGE_WORDS = 128;
  localparam int RWW_PAGES = 224;
  localparam int NO_CONCURRENT_READ_REGION_PAGES = 32;
  localparam logic [14:0] NO_CONCURRENT_READ_REGION_START = 15'h7000;
  localparam logic [14:0] BOOT_START_11 = 15'h7e00;
  localparam logic [14:0] BOOT_START_10 = 15'h7c00;
  localparam logic [14:0] BOOT_START_01 = 15'h7800;
  localparam logic [14:0] BOOT_START_00 = 15'h7000;
  // control register bit positions
  localparam int CR_ENABLE = 0;
  localparam int CR_ERASE = 1;
  localparam int CR_WRITE = 2;
  localparam int CR_LOCK = 3;
  localparam int CR_REEN = 4;
  localparam int CR_BUSY = 6;
  // APB register offsets and status bit positions of the controller end
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_PTR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int ST_BUSY = 0;
  localparam int ST_REGION = 1;
  localparam int ST_DONE = 2;
endpackage

// file: rtl/fsp_sequencer.sv
// Functional notes
// (RQ1) page erase timed 7.3 to 8.9 ms
// (RQ2) page or lock write 3.7 to 4.5 ms
// (RQ3) 224 read-while-write pages, 32 above 0x7000
// (RQ4) during erase/write fetch only upper region
// (RQ5) program counter is 15 bits wide
// (RQ6) page holds 128 words, bits 6:0
// (RQ7) page index from pointer bits 15:8
// (RQ8) word index from pointer bits 7:1
// (RQ9) software keeps pointer bit zero cleared
// (RQ10) boot-size fuse selects boot start
// (RQ11) busy flag holds until re-enable command
// (RQ12) software re-enables region before reading it
// (RQ13) software polls enable bit before next command
// (RQ14) software waits for eeprom write idle
// (RQ15) software fills buffer word by word
// (RQ16) software relocates vectors or masks interrupts
// (RQ17) store within four cycles, else ignored
// (RQ18) eeprom write blocks flash programming
// (RQ19) enable bit self-clears when operation ends
// (RQ20) erase sets whole page to ones
//
// Purpose: device end: control register, page buffer, flash array, timing
// Assumes: fetch port is synchronous, one word per cycle
// Notes: flash array is modelled as a register array
`timescale 1ns/10ps
module fsp_sequencer import fsp_pkg::*; #(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  fsp_if.dev LINK,
  input wire logic [1:0] BOOT_SIZE_SELECT,
  input wire logic [14:0] FETCH_ADDR,
  output logic [15:0] FETCH_DATA,
  output logic FETCH_STALL,
  output logic [14:0] BOOT_START,
  output logic [14:0] APP_END,
  output logic [5:0] LOCK_BITS
);
  initial begin
    if (ERASE_CYCLES < 1 || WRITE_CYCLES < 1 || ERASE_CYCLES >= (1 << 24)) begin
      $error("fsp_sequencer: bad cycle count");
    end
  end

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ARMED = 5'b00010,
    S_ERASE = 5'b00100,
    S_WRITE = 5'b01000,
    S_LOCK = 5'b10000
  } fsp_state_type;

  typedef struct packed {
    fsp_state_type st;
    logic [7:0] cr;
    logic [1:0] win;
    logic [23:0] cnt;
    logic [7:0] page;
    logic busy;
    logic [5:0] lock;
    logic [15:0] fdata;
    logic stall;
    logic [14:0] boot;
    logic [14:0] app_end;
  } fsp_regs_type;

  localparam int WORDS = PAGE_WORDS * (RWW_PAGES + NO_CONCURRENT_READ_REGION_PAGES);
  logic [15:0] flash_mem [WORDS];
  logic [15:0] page_buf [PAGE_WORDS];
  fsp_regs_type r_q, r_d;
  logic [14:0] addr_pc; // [RQ5]
  logic [7:0] pidx;
  logic [6:0] widx;
  logic fetch_no_concurrent_read_region;
  logic mem_erase, mem_write, buf_fill;

  assign pidx = LINK.zptr[15:8]; // [RQ7]
  assign widx = LINK.zptr[7:1]; // [RQ8] [RQ6]
  assign addr_pc = {pidx, widx};
  assign fetch_no_concurrent_read_region = FETCH_ADDR >= NO_CONCURRENT_READ_REGION_START; // [RQ3]

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_d = r_q;
    mem_erase = 1'b0;
    mem_write = 1'b0;
    buf_fill = 1'b0;
    unique case (BOOT_SIZE_SELECT) // [RQ10]
      2'b11: r_d.boot = BOOT_START_11;
      2'b10: r_d.boot = BOOT_START_10;
      2'b01: r_d.boot = BOOT_START_01;
      2'b00: r_d.boot = BOOT_START_00;
    endcase
    r_d.app_end = r_d.boot - 15'h0001;
    unique case (r_q.st)
      S_IDLE: begin
        // eeprom write blocks the control register entirely
        if (LINK.cr_wr && !LINK.eeprom_write_active && LINK.cr_wdata[CR_ENABLE]) begin // [RQ18]
          r_d.cr = {1'b0, r_q.busy, 1'b0, LINK.cr_wdata[4:0]};
          r_d.win = 2'h0;
          r_d.st = S_ARMED;
        end
      end
      S_ARMED: begin
        if (LINK.spm_exec) begin
          r_d.cnt = 24'h000000;
          if (r_q.cr[CR_ERASE]) begin
            r_d.st = S_ERASE;
            r_d.page = pidx;
            r_d.busy = 1'b1; // [RQ11]
          end else if (r_q.cr[CR_WRITE]) begin
            r_d.st = S_WRITE;
            r_d.page = pidx;
            r_d.busy = 1'b1; // [RQ11]
          end else if (r_q.cr[CR_LOCK]) begin
            r_d.st = S_LOCK;
          end else begin
            if (r_q.cr[CR_REEN]) begin
              r_d.busy = 1'b0; // [RQ11]
            end else begin
              buf_fill = 1'b1;
            end
            r_d.cr = 8'h00; // [RQ19]
            r_d.st = S_IDLE;
          end
        end else if (r_q.win == 2'(SPM_WINDOW_CYC - 1)) begin
          r_d.cr = 8'h00; // [RQ17]
          r_d.st = S_IDLE;
        end else begin
          r_d.win = r_q.win + 2'h1;
        end
      end
      S_ERASE, S_WRITE, S_LOCK: begin
        r_d.cnt = r_q.cnt + 24'h000001;
        if ((r_q.st == S_ERASE && r_q.cnt == 24'(ERASE_CYCLES - 1)) // [RQ1]
          || (r_q.st != S_ERASE && r_q.cnt == 24'(WRITE_CYCLES - 1))) begin // [RQ2]
          mem_erase = r_q.st == S_ERASE;
          mem_write = r_q.st == S_WRITE;
          if (r_q.st == S_LOCK) begin
            r_d.lock = r_q.lock & LINK.lock_data[5:0];
          end
          r_d.cr = 8'h00; // [RQ19]
          r_d.st = S_IDLE;
        end
      end
    endcase
    r_d.cr[CR_BUSY] = r_d.busy;
    r_d.fdata = flash_mem[FETCH_ADDR];
    // other region is stalled from erase or write start until the busy flag is cleared
    r_d.stall = (r_d.st == S_ERASE || r_d.st == S_WRITE || r_d.busy) && !fetch_no_concurrent_read_region; // [RQ4]
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      r_q <= '{st: S_IDLE, lock: 6'h3f, boot: BOOT_START_11, app_end: 15'h7dff, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // array contents are not reset; buffer keeps last data, as on silicon
  always_ff @(posedge CORE_CLK) begin
    if (buf_fill) begin
      page_buf[widx] <= LINK.wdata; // [RQ8]
    end
    for (int i = 0; i < PAGE_WORDS; i++) begin
      if (mem_erase) begin
        flash_mem[{r_q.page, 7'(i)}] <= 16'hffff; // [RQ20]
      end else if (mem_write) begin
        flash_mem[{r_q.page, 7'(i)}] <= page_buf[i];
      end
    end
  end

  assign LINK.cr_rdata = r_q.cr;
  assign FETCH_DATA = r_q.fdata;
  assign FETCH_STALL = r_q.stall;
  assign BOOT_START = r_q.boot;
  assign APP_END = r_q.app_end;
  assign LOCK_BITS = r_q.lock;
endmodule

// file: test/flash_self_program_sequencer_bench.sv
// Purpose: both ends joined by the link, driven over apb
// Assumes: erase 20 and write 10 cycles
// Notes: flash contents are known only where this bench wrote them
`timescale 1ns/10ps
module flash_self_program_sequencer_bench import fsp_pkg::*;;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, eew = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, fstall;
  logic [1:0] bsel = 2'h3;
  logic [14:0] faddr = 15'h7000, bstart, aend;
  logic [15:0] fdata;
  logic [5:0] lbits;
  logic [14:0] bs [4] = '{15'h7000, 15'h7800, 15'h7c00, 15'h7e00};
  int errors = 0, tests_run = 0;
  fsp_if i_fsp_if();
  fsp_sequencer #(.ERASE_CYCLES(20), .WRITE_CYCLES(10)) i_fsp_sequencer (.CORE_CLK(core_clk),
    .RST(rst), .LINK(i_fsp_if), .BOOT_SIZE_SELECT(bsel), .FETCH_ADDR(faddr),
    .FETCH_DATA(fdata), .FETCH_STALL(fstall), .BOOT_START(bstart), .APP_END(aend),
    .LOCK_BITS(lbits));
  fsp_controller i_fsp_controller (.CORE_CLK(core_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EEPROM_WRITE_ACTIVE(eew), .LINK(i_fsp_if));
  fsp_monitor #(.ERASE_CYCLES(20), .WRITE_CYCLES(10)) i_fsp_monitor (.CORE_CLK(core_clk),
    .RST(rst), .cr_wr(i_fsp_if.cr_wr), .cr_wdata(i_fsp_if.cr_wdata),
    .cr_rdata(i_fsp_if.cr_rdata), .spm_exec(i_fsp_if.spm_exec), .zptr(i_fsp_if.zptr),
    .wdata(i_fsp_if.wdata), .lock_data(i_fsp_if.lock_data),
    .eeprom_write_active(i_fsp_if.eeprom_write_active));
  always #2.5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one transfer; read data and error are taken at the pready edge, or after 20 cycles if pready never comes
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk(pready, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 100);
    chk(rd[ST_BUSY], 32'h0);
  endtask
  task cmd(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d);
    apb(1'b1, REG_PTR, {16'h0, p});
    apb(1'b1, REG_DATA, {16'h0, d});
    apb(1'b1, REG_CMD, {24'h0, c});
    chk(er, 32'h0);
  endtask
  task fetch(input logic [14:0] a, input logic s);
    @(posedge core_clk);
    faddr <= a;
    // a command becomes visible on the link only a few cycles after its bus write
    repeat (4) @(posedge core_clk);
    #1;
    chk(fstall, s);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_fuse;
    chk(lbits, 32'h3f);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      bsel <= 2'(i);
      repeat (3) @(posedge core_clk);
      chk(bstart, bs[i]);
      chk(aend, bs[i] - 15'h1);
    end
  endtask
  task t_program;
    cmd(8'h02, 16'h2000, 16'h0);
    fetch(15'h6fff, 1'b1);
    fetch(15'h7000, 1'b0);
    wait_idle;
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd[ST_REGION], 32'h1);
    fetch(15'h1000, 1'b1);
    cmd(8'h10, 16'h0, 16'h0);
    wait_idle;
    fetch(15'h1000, 1'b0);
    chk(fdata, 32'hffff);
    fetch(15'h107f, 1'b0);
    chk(fdata, 32'hffff);
    cmd(8'h00, 16'h200a, 16'hbeef);
    wait_idle;
    cmd(8'h00, 16'h20fe, 16'h1234);
    wait_idle;
    cmd(8'h04, 16'h2000, 16'h0);
    wait_idle;
    cmd(8'h10, 16'h0, 16'h0);
    wait_idle;
    fetch(15'h1005, 1'b0);
    chk(fdata, 32'hbeef);
    fetch(15'h107f, 1'b0);
    chk(fdata, 32'h1234);
  endtask
  task t_lock;
    cmd(8'h08, 16'h0, 16'h002a);
    wait_idle;
    // pending clears at the store strobe; the lock write itself runs ten more cycles
    repeat (15) @(posedge core_clk);
    chk(lbits, 32'h2a);
  endtask
  // a command stays pending while the eeprom writes; a second one is refused
  task t_eeprom;
    @(posedge core_clk);
    eew <= 1'b1;
    cmd(8'h00, 16'h2002, 16'h5555);
    repeat (10) @(posedge core_clk);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd[ST_BUSY], 32'h1);
    apb(1'b1, REG_CMD, 32'h0);
    chk(er, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    @(posedge core_clk);
    eew <= 1'b0;
    wait_idle;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_fuse;
    t_program;
    t_lock;
    t_eeprom;
    wrap_up;
  end
  initial begin
    #200000;
    errors++;
    wrap_up;
  end
endmodule

// file: test/fsp_monitor.sv
// Purpose: link checker between controller and sequencer
// Assumes: shortened erase and write counts handed in as parameters
// Notes: instantiated beside the link, no bind
`timescale 1ns/10ps
module fsp_monitor import fsp_pkg::*; #(
  parameter int ERASE_CYCLES = 20,
  parameter int WRITE_CYCLES = 10
) (
  input logic CORE_CLK,
  input logic RST,
  input logic cr_wr,
  input logic [7:0] cr_wdata,
  input logic [7:0] cr_rdata,
  input logic spm_exec,
  input logic [15:0] zptr,
  input logic [15:0] wdata,
  input logic [7:0] lock_data,
  input logic eeprom_write_active
);
  // a margin of three cycles either side of the count; the hand-over is two edges deep
  localparam int ER_LO = ERASE_CYCLES - 3;
  localparam int WR_LO = WRITE_CYCLES - 3;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////////////
  AST_ERASE_TIME: assert property ((cr_wr && cr_wdata[CR_ERASE]) ##1 spm_exec |->
    ##ER_LO cr_rdata[CR_ENABLE] ##[1:6] !cr_rdata[CR_ENABLE]) else $error("erase time off");
  AST_WRITE_TIME: assert property ((cr_wr && (cr_wdata[CR_WRITE] || cr_wdata[CR_LOCK]))
    ##1 spm_exec |-> ##WR_LO cr_rdata[CR_ENABLE] ##[1:6] !cr_rdata[CR_ENABLE])
    else $error("write time off");
  AST_FILL_CLEAR: assert property ((cr_wr && cr_wdata[4:1] == 4'h0) ##1 spm_exec |->
    ##[1:2] !cr_rdata[CR_ENABLE]) else $error("fill enable stuck");
  AST_ENABLE_SET: assert property (cr_wr && !eeprom_write_active |=>
    cr_rdata[CR_ENABLE]) else $error("enable not set");
  AST_BUSY_SET: assert property ((cr_wr && (cr_wdata[CR_ERASE] || cr_wdata[CR_WRITE]))
    ##1 spm_exec |-> ##[1:3] cr_rdata[CR_BUSY]) else $error("busy flag not set");
  AST_BUSY_HOLD: assert property ($fell(cr_rdata[CR_BUSY]) |->
    $past(spm_exec) || $past(spm_exec, 2)) else $error("busy flag fell alone");
  AST_ZERO_BIT: assert property (spm_exec |-> !zptr[0]) else $error("pointer bit zero set");
  AST_WORD_ZERO: assert property (spm_exec && $past(cr_wr && cr_wdata[CR_WRITE]) |->
    zptr[7:1] == 7'h00) else $error("word index not zero");
  AST_EE_BLOCK: assert property (cr_wr |-> !eeprom_write_active)
    else $error("command during eeprom write");
  AST_POLL_IDLE: assert property (cr_wr |-> !cr_rdata[CR_ENABLE])
    else $error("command while enable set");
  AST_SPM_SOON: assert property (cr_wr |=> ##[0:3] spm_exec) else $error("store too late");
endmodule
